// ===== hdl/buffer_pkg.sv
// Shared types, constants and decoders for the configurable registered buffer.
// Summary of operation
// R1 - Sample data, termination and clock-enable inputs only at the rising clock edge.
// R2 - Low reset clears every flip-flop except the FIFO storage at once and holds all outputs low except inReady, which is high.
// R3 - Reset overrides chip-select gating; outputs stay low even with both selects high.
// R4 - Both chip selects high at an edge: gated data keeps its previous value.
// R5 - Either chip select low at an edge the FIFO is not full: gated data loads the sampled inputs.
// R6 - Termination and clock-enable copies load every edge the FIFO is not full, ignoring chip selects.
// R7 - Chip-select copies follow the primary select every edge the FIFO is not full and hold while it is full.
// R8 - Between edges every output holds; input changes have no effect.
// R9 - Both straps low: one-to-one, bits 2,3,5,6,8-25 each drive one output.
// R10 - Pinout low, fan-out high: gated inputs are bits 2,3,5,6,8-14.
// R11 - Both straps high: gated inputs are bits 1-6, 8-10, 12, 13.
// R12 - Fan-out modes: each register drives identical A and B copies, updated together.
// R13 - The two impedance-reserved inputs influence no register or output.
// R14 - Configuration straps are held static while the register operates.
package buffer_pkg;

   // Widths and depths of the data path.
   localparam int DATA_BITS = 25;
   localparam int FIFO_DEPTH = 16;

   // Active gated data bits of each configuration, bit n stands for data bit n.
   localparam logic [25:1] MASK_ONE_TO_ONE = 25'h1ffffb6;
   localparam logic [25:1] MASK_FAN_A = 25'h0003fb6;
   localparam logic [25:1] MASK_FAN_B = 25'h0001bbf;

   // Values after reset.
   localparam logic [1:0] STRAP_RESET = 2'h0;
   localparam logic CAPTURE_VALID_RESET = 1'h0;

   // Operating configurations selected by the two straps.
   typedef enum logic [1:0] {
      MODE_ONE_TO_ONE = 2'b00,
      MODE_FAN_A = 2'b01,
      MODE_FAN_B = 2'b10
   } mode_t;

   // One registered command word as it travels through the buffer.
   typedef struct packed {
      logic [25:1] data;
      logic cs;
      logic odt;
      logic cke;
   } cmdWord_t;

   localparam int WORD_BITS = $bits(cmdWord_t);
   localparam cmdWord_t CMD_WORD_RESET = '0;

   // Decodes the straps; a low fan-out strap always means one-to-one.
   function automatic mode_t decodeMode(input logic pinout, input logic fanout);
      mode_t m;
      m = MODE_ONE_TO_ONE;
      if (fanout) begin
         m = pinout ? MODE_FAN_B : MODE_FAN_A;
      end
      return m;
   endfunction

   // Returns the set of data bits that are live in a configuration.
   function automatic logic [25:1] modeMask(input mode_t mode);
      logic [25:1] mask;
      mask = MASK_ONE_TO_ONE;
      case (mode)
         MODE_ONE_TO_ONE: mask = MASK_ONE_TO_ONE;
         MODE_FAN_A: mask = MASK_FAN_A;
         MODE_FAN_B: mask = MASK_FAN_B;
         default: mask = MASK_ONE_TO_ONE;
      endcase
      return mask;
   endfunction

endpackage

// ===== hdl/sync_two_ff.sv
// Two flip-flop synchroniser with asynchronous clear to zero.
`timescale 1ns/100ps
`default_nettype none
module sync_two_ff #(
   parameter int WIDTH = 1
) (
   // Clock and clear
   input wire logic clock,
   input wire logic clearN,
   // Level in and out
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] stage1;

   // The first stage feeds only the second stage.
   always_ff @(posedge clock or negedge clearN) begin
      if (!clearN) begin
         stage1 <= '0;
         q <= '0;
      end else begin
         stage1 <= d;
         q <= stage1;
      end
   end

endmodule
`default_nettype wire

// ===== hdl/cmd_fifo.sv
// Flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/100ps
`default_nettype none
module cmd_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clock,
   input wire logic resetN,
   // Filling side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // Draining side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);

   localparam int PTR_BITS = $clog2(DEPTH);
   localparam int CNT_BITS = $clog2(DEPTH + 1);
   localparam logic [CNT_BITS-1:0] FULL_COUNT = CNT_BITS'(DEPTH);
   localparam logic [PTR_BITS-1:0] LAST_SLOT = PTR_BITS'(DEPTH - 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_BITS-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
   logic [CNT_BITS-1:0] count, next_count;
   logic push, pop;

   // Honest flags and head of queue.
   assign inReady = (count != FULL_COUNT);
   assign outValid = (count != '0);
   assign outData = mem[rdPtr];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   // Pointer and occupancy update with wrap at the last slot.
   always_comb begin
      next_wrPtr = wrPtr;
      next_rdPtr = rdPtr;
      next_count = count;
      if (push) begin
         next_wrPtr = (wrPtr == LAST_SLOT) ? '0 : wrPtr + 1'b1;
      end
      if (pop) begin
         next_rdPtr = (rdPtr == LAST_SLOT) ? '0 : rdPtr + 1'b1;
      end
      if (push && !pop) begin
         next_count = count + 1'b1;
      end else if (pop && !push) begin
         next_count = count - 1'b1;
      end
   end

   // Registers the pointers and the count.
   always_ff @(posedge clock or negedge resetN) begin
      if (!resetN) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         wrPtr <= next_wrPtr;
         rdPtr <= next_rdPtr;
         count <= next_count;
      end
   end

   // Storage is written only on an accepted push.
   always_ff @(posedge clock) begin
      if (push) begin
         mem[wrPtr] <= inData;
      end
   end

endmodule
`default_nettype wire

// ===== hdl/configurable_registered_buffer.sv
// Configurable one-to-one or one-to-two registered command buffer.
`timescale 1ns/100ps
`default_nettype none
module configurable_registered_buffer (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Configuration straps
   input wire logic pinoutSelect,
   input wire logic fanoutSelect,
   input wire logic impedanceReservedHigh,
   input wire logic impedanceReservedLow,
   // Command inputs from the controller
   input wire logic primaryChipSelectN,
   input wire logic secondaryChipSelectN,
   input wire logic terminationCtlIn,
   input wire logic clockEnableCtlIn,
   input wire logic [25:1] dataInBit,
   // Flow control
   input wire logic outReady,
   output logic inReady,
   // Registered outputs, A copy or one-to-one
   output logic [25:1] gatedDataOut,
   output logic chipSelectCopyOut,
   output logic terminationCtlOut,
   output logic clockEnableCtlOut,
   // Registered outputs, B copy
   output logic [25:1] gatedDataOutB,
   output logic chipSelectCopyOutB,
   output logic terminationCtlOutB,
   output logic clockEnableCtlOutB
);

   logic rstSyncN;
   logic [1:0] strapSync;
   buffer_pkg::mode_t mode;
   logic [25:1] liveMask;
   logic bothDeselected;
   logic fanOut;

   buffer_pkg::cmdWord_t capWord, next_capWord;
   logic capValid, next_capValid;
   logic [buffer_pkg::WORD_BITS-1:0] fifoData;
   logic fifoOutValid;
   buffer_pkg::cmdWord_t fifoWord;
   logic outLoad;

   buffer_pkg::cmdWord_t outWord, next_outWord;
   buffer_pkg::cmdWord_t outWordB, next_outWordB;

   // Reset asserts at once and is released through two flip-flops.
   sync_two_ff #(
      .WIDTH(1)
   ) resetSync (
      .clock(clock),
      .clearN(rstn),
      .d(1'b1),
      .q(rstSyncN)
   );

   // Straps are pins, so they pass two flip-flops before use.
   sync_two_ff #(
      .WIDTH(2)
   ) strapSyncer (
      .clock(clock),
      .clearN(rstn),
      .d({fanoutSelect, pinoutSelect}),
      .q(strapSync)
   );

   // Mode decode from the synchronised straps.
   // R9 R10 R11 mode data masks
   always_comb begin
      mode = buffer_pkg::decodeMode(strapSync[0], strapSync[1]);
      liveMask = buffer_pkg::modeMask(mode);
      fanOut = (mode != buffer_pkg::MODE_ONE_TO_ONE);
   end

   // Gating is active only when both selects are high.
   assign bothDeselected = primaryChipSelectN && secondaryChipSelectN;

   // Capture stage next values; stalls only while the FIFO is full.
   always_comb begin
      next_capWord = capWord;
      next_capValid = capValid;
      if (inReady) begin
         next_capValid = 1'b1;
         // R6 controls load freely
         next_capWord.odt = terminationCtlIn;
         next_capWord.cke = clockEnableCtlIn;
         // R7 chip select copy
         next_capWord.cs = primaryChipSelectN;
         // R5 load when selected
         if (!bothDeselected) begin
            // R13 reserved inputs unused
            next_capWord.data = dataInBit & liveMask;
         end
         // R4 hold when deselected
      end
   end

   // Capture stage registers, sampled on the rising edge only.
   // R1 rising edge sampling
   // R8 hold between edges
   always_ff @(posedge clock or negedge rstSyncN) begin
      if (!rstSyncN) begin
         capWord <= buffer_pkg::CMD_WORD_RESET;
         capValid <= buffer_pkg::CAPTURE_VALID_RESET;
      end else begin
         capWord <= next_capWord;
         capValid <= next_capValid;
      end
   end

   // Elastic buffer between capture and the output drivers.
   cmd_fifo #(
      .WIDTH(buffer_pkg::WORD_BITS),
      .DEPTH(buffer_pkg::FIFO_DEPTH)
   ) wordFifo (
      .clock(clock),
      .resetN(rstSyncN),
      .inValid(capValid),
      .inReady(inReady),
      .inData(capWord),
      .outValid(fifoOutValid),
      .outReady(outReady),
      .outData(fifoData)
   );

   assign fifoWord = buffer_pkg::cmdWord_t'(fifoData);
   assign outLoad = fifoOutValid && outReady;

   // Output stage next values; the B copy is live only in fan-out modes.
   always_comb begin
      next_outWord = outWord;
      next_outWordB = outWordB;
      if (outLoad) begin
         next_outWord = fifoWord;
         // R12 identical B copy
         next_outWordB = fanOut ? fifoWord : buffer_pkg::CMD_WORD_RESET;
      end
   end

   // Output registers; reset forces them low whatever the selects do.
   // R2 asynchronous clear
   // R3 reset beats gating
   always_ff @(posedge clock or negedge rstSyncN) begin
      if (!rstSyncN) begin
         outWord <= buffer_pkg::CMD_WORD_RESET;
         outWordB <= buffer_pkg::CMD_WORD_RESET;
      end else begin
         outWord <= next_outWord;
         outWordB <= next_outWordB;
      end
   end

   // Output pins come straight from the output registers.
   assign gatedDataOut = outWord.data;
   assign chipSelectCopyOut = outWord.cs;
   assign terminationCtlOut = outWord.odt;
   assign clockEnableCtlOut = outWord.cke;
   assign gatedDataOutB = outWordB.data;
   assign chipSelectCopyOutB = outWordB.cs;
   assign terminationCtlOutB = outWordB.odt;
   assign clockEnableCtlOutB = outWordB.cke;

   // Every output except inReady is low whenever the internal reset is active.
   // R2 outputs low
   a_reset_outputs_low: assert property (@(posedge clock)
      !rstSyncN |-> (outWord == '0) && (outWordB == '0) && !capValid) // R2
      else $error("Outputs not low during reset.");

   // Both selects high at reset still leaves the outputs low.
   // R3 reset priority
   a_reset_over_gate: assert property (@(posedge clock)
      (!rstSyncN && bothDeselected) |=> !rstSyncN || (gatedDataOut == '0)) // R3
      else $error("Gating overrode reset.");

   // Deselected edge keeps the captured gated data.
   // R4 gated hold
   a_gated_data_hold: assert property (@(posedge clock) disable iff (!rstSyncN)
      (bothDeselected && inReady) |=> capWord.data == $past(capWord.data)) // R4
      else $error("Gated data changed while deselected.");

   // Selected edge loads the masked inputs.
   // R5 normal load
   a_selected_data_load: assert property (@(posedge clock) disable iff (!rstSyncN)
      (!bothDeselected && inReady) |=> capWord.data == $past(dataInBit & liveMask)) // R5
      else $error("Gated data failed to load while selected.");

   // Controls load on every accepted edge regardless of the selects.
   // R6 controls ungated
   a_ctl_always_load: assert property (@(posedge clock) disable iff (!rstSyncN)
      inReady |=> (capWord.odt == $past(terminationCtlIn))
                  && (capWord.cke == $past(clockEnableCtlIn))) // R6
      else $error("Control copy did not load.");

   // Select copy tracks the primary select only.
   // R7 select copy
   a_cs_copy_track: assert property (@(posedge clock) disable iff (!rstSyncN)
      inReady |=> capWord.cs == $past(primaryChipSelectN)) // R7
      else $error("Chip select copy did not follow the primary select.");

   // Outputs hold unless a word is taken from the buffer.
   // R8 outputs hold
   a_output_hold: assert property (@(posedge clock) disable iff (!rstSyncN)
      !outLoad |=> $stable(outWord) && $stable(outWordB)) // R8
      else $error("Output changed without a load.");

   // With free drain, an input reaches the pins two edges after capture.
   // R1 edge pipeline
   a_pipe_latency: assert property (@(posedge clock) disable iff (!rstSyncN)
      (inReady && capValid && outReady && !fifoOutValid) ##1 outReady
      |=> terminationCtlOut == $past(terminationCtlIn, 3)) // R1
      else $error("Captured control did not reach the output in time.");

   // One-to-one mode drives only its live bits.
   // R9 one-to-one bits
   a_one_to_one_bits: assert property (@(posedge clock) disable iff (!rstSyncN)
      (mode == buffer_pkg::MODE_ONE_TO_ONE)
      |-> (capWord.data & ~buffer_pkg::MASK_ONE_TO_ONE) == '0) // R9
      else $error("Dead bit set in one-to-one mode.");

   // Fan-out A mode drives only its live bits.
   // R10 fan-out A bits
   a_fan_a_bits: assert property (@(posedge clock) disable iff (!rstSyncN)
      (mode == buffer_pkg::MODE_FAN_A) ##1 (mode == buffer_pkg::MODE_FAN_A)
      |-> (capWord.data & ~buffer_pkg::MASK_FAN_A) == '0) // R10
      else $error("Dead bit set in fan-out A mode.");

   // Fan-out B mode drives only its live bits.
   // R11 fan-out B bits
   a_fan_b_bits: assert property (@(posedge clock) disable iff (!rstSyncN)
      (mode == buffer_pkg::MODE_FAN_B) ##1 (mode == buffer_pkg::MODE_FAN_B)
      |-> (capWord.data & ~buffer_pkg::MASK_FAN_B) == '0) // R11
      else $error("Dead bit set in fan-out B mode.");

   // A and B copies load together in fan-out modes.
   // R12 copies match
   a_copies_match: assert property (@(posedge clock) disable iff (!rstSyncN)
      (outLoad && fanOut) |=> outWordB == outWord) // R12
      else $error("B copy differs from A copy.");

   // The buffer accepts words again as soon as reset empties it.
   // R2 ready in reset
   a_ready_in_reset: assert property (@(posedge clock)
      !rstSyncN |-> inReady) // R2
      else $error("Input not ready during reset.");

   // A full buffer takes nothing, so the capture stage holds its word.
   // R1 stalled capture
   a_capture_stall: assert property (@(posedge clock) disable iff (!rstSyncN)
      !inReady |=> $stable(capWord)) // R1
      else $error("Capture changed while the buffer was full.");

   // In one-to-one mode the B copy is loaded with zero.
   // R12 idle B copy
   a_b_copy_idle: assert property (@(posedge clock) disable iff (!rstSyncN)
      (outLoad && !fanOut) |=> outWordB == '0) // R12
      else $error("B copy not zero in one-to-one mode.");

   // The output data takes the oldest buffered word.
   // R5 output data load
   a_out_data_load: assert property (@(posedge clock) disable iff (!rstSyncN)
      outLoad |=> gatedDataOut == $past(fifoWord.data)) // R5
      else $error("Output data did not take the buffered word.");

   // The output controls take the oldest buffered word.
   // R6 output control load
   a_out_ctl_load: assert property (@(posedge clock) disable iff (!rstSyncN)
      outLoad |=> (terminationCtlOut == $past(fifoWord.odt))
                  && (clockEnableCtlOut == $past(fifoWord.cke))) // R6
      else $error("Output controls did not take the buffered word.");

   // The output select copy takes the oldest buffered word.
   // R7 output select copy
   a_out_cs_load: assert property (@(posedge clock) disable iff (!rstSyncN)
      outLoad |=> chipSelectCopyOut == $past(fifoWord.cs)) // R7
      else $error("Output select copy did not take the buffered word.");

   // One-to-one mode shows no dead bit on the output pins.
   // R9 output live bits
   a_out_one_bits: assert property (@(posedge clock) disable iff (!rstSyncN)
      (mode == buffer_pkg::MODE_ONE_TO_ONE)
      |-> (gatedDataOut & ~buffer_pkg::MASK_ONE_TO_ONE) == '0) // R9
      else $error("Dead output bit set in one-to-one mode.");

   // Fan-out B mode shows no dead bit on the output pins.
   // R11 output live bits
   a_out_fan_b_bits: assert property (@(posedge clock) disable iff (!rstSyncN)
      (mode == buffer_pkg::MODE_FAN_B) ##1 (mode == buffer_pkg::MODE_FAN_B)
      |-> (gatedDataOut & ~buffer_pkg::MASK_FAN_B) == '0) // R11
      else $error("Dead output bit set in fan-out B mode.");

   // Reserved inputs toggling alone never move the captured word.
   // R13 reserved ignored
   a_reserved_ignored: assert property (@(posedge clock) disable iff (!rstSyncN)
      (inReady && $past(inReady) && $stable(dataInBit) && $stable(primaryChipSelectN)
       && $stable(secondaryChipSelectN)
       && $stable(terminationCtlIn) && $stable(clockEnableCtlIn)
       && $stable(strapSync) && capValid
       && ($changed(impedanceReservedHigh) || $changed(impedanceReservedLow)))
      |=> $stable(capWord)) // R13
      else $error("Reserved input affected the register.");

endmodule
`default_nettype wire

// ===== verification/dram_sink_model.sv
// Downstream sink model that paces the buffer output through outReady.
`timescale 1ns/100ps
`default_nettype none
module dram_sink_model (
   // Clock and pacing: 0 prompt, 1 random stalls, 2 stalled
   input wire logic clock,
   input wire logic [1:0] paceMode,
   // Flow control toward the buffer
   output logic outReady
);
   int seed = 32'h55287541;

   // A new pacing decision after each falling edge holds over the rising edge.
   initial begin
      outReady = 1'b1;
      forever begin
         @(negedge clock);
         case (paceMode)
            2'h0: outReady <= 1'b1;
            2'h1: outReady <= 1'($random(seed));
            default: outReady <= 1'b0;
         endcase
      end
   end
endmodule
`default_nettype wire

// ===== verification/configurable_registered_buffer_tb.sv
// Self-checking bench for the configurable registered buffer.
`timescale 1ns/100ps
`default_nettype none
module configurable_registered_buffer_tb;
   logic clock, rstn, pinoutSelect, fanoutSelect, zHigh, zLow;
   logic csPrim, csSec, odtIn, ckeIn, outReady, inReady;
   logic csOut, odtOut, ckeOut, csOutB, odtOutB, ckeOutB, fanMode, popNow;
   logic [25:1] dataInBit, gatedDataOut, gatedDataOutB, mask, lastData;
   logic [27:0] heldA;
   logic [1:0] paceMode;
   buffer_pkg::cmdWord_t expQ[$];
   buffer_pkg::cmdWord_t expW;
   int takeQ[$];
   int seed = 32'h55287541;
   int miscompares = 0;
   int checks = 0;
   int edgeCnt = 0;
   int settle = 0;

   configurable_registered_buffer configurable_registered_buffer_i (
      .clock(clock), .rstn(rstn), .pinoutSelect(pinoutSelect), .fanoutSelect(fanoutSelect),
      .impedanceReservedHigh(zHigh), .impedanceReservedLow(zLow),
      .primaryChipSelectN(csPrim), .secondaryChipSelectN(csSec),
      .terminationCtlIn(odtIn), .clockEnableCtlIn(ckeIn), .dataInBit(dataInBit),
      .outReady(outReady), .inReady(inReady), .gatedDataOut(gatedDataOut),
      .chipSelectCopyOut(csOut), .terminationCtlOut(odtOut), .clockEnableCtlOut(ckeOut),
      .gatedDataOutB(gatedDataOutB), .chipSelectCopyOutB(csOutB),
      .terminationCtlOutB(odtOutB), .clockEnableCtlOutB(ckeOutB));

   dram_sink_model dram_sink_model_i (.clock(clock), .paceMode(paceMode), .outReady(outReady));

   // The clock runs at 100 MHz.
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test();
      $display("Checks %0d, miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Compares one output word.
   task automatic cmpWord(string what, logic [27:0] exp, logic [27:0] got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Compares one flag.
   task automatic cmpFlag(string what, logic exp, logic got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %b seen %b", what, exp, got);
      end
   endtask

   // Drives one random word and notes it when the next edge will take it.
   task automatic sendWord();
      buffer_pkg::cmdWord_t w;
      @(negedge clock);
      {csPrim, csSec, odtIn, ckeIn, zHigh, zLow} = 6'($random(seed));
      dataInBit = 25'($random(seed));
      w.cs = csPrim;
      w.odt = odtIn;
      w.cke = ckeIn;
      // data keeps its last value while both selects are high
      w.data = (csPrim && csSec) ? lastData : (dataInBit & mask);
      if (settle == 0 && inReady === 1'b1) begin
         lastData = w.data;
         expQ.push_back(w);
         takeQ.push_back(edgeCnt + 1);
      end
      if (settle > 0) begin
         settle--;
      end
   endtask

   // Resets with new straps; selects stay high so reset must beat the gating.
   task automatic doReset(logic pin, logic fan);
      @(negedge clock);
      rstn = 1'b0;
      {csPrim, csSec} = 2'b11;
      #1;
      cmpWord("reset A", 28'h0, {gatedDataOut, csOut, odtOut, ckeOut});
      cmpWord("reset B", 28'h0, {gatedDataOutB, csOutB, odtOutB, ckeOutB});
      cmpFlag("ready in reset", 1'b1, inReady);
      // straps move only while reset is held
      pinoutSelect = pin;
      fanoutSelect = fan;
      fanMode = fan;
      mask = !fan ? buffer_pkg::MASK_ONE_TO_ONE :
         (pin ? buffer_pkg::MASK_FAN_B : buffer_pkg::MASK_FAN_A);
      expQ.delete();
      takeQ.delete();
      lastData = '0;
      repeat (10) begin
         @(negedge clock);
         {odtIn, ckeIn} = 2'($random(seed));
         dataInBit = 25'($random(seed));
      end
      cmpWord("reset held", 28'h0, {gatedDataOut, csOut, odtOut, ckeOut});
      rstn = 1'b1;
      settle = 1;
   endtask

   // Stalls the sink until the FIFO refuses, then holds the refusal a while.
   task automatic fillUp();
      int n;
      paceMode = 2'h2;
      n = 0;
      while (inReady === 1'b1 && n < 40) begin
         sendWord();
         n++;
      end
      cmpFlag("refused at depth", 1'b1, expQ.size() inside {[16:17]});
      repeat (4) sendWord();
      cmpFlag("still refused", 1'b0, inReady);
   endtask

   // each pop shows the oldest noted word on copy A, and on copy B in fan-out modes
   always @(posedge clock) begin
      edgeCnt++;
      popNow = rstn && outReady === 1'b1 && takeQ.size() > 0 && takeQ[0] <= edgeCnt - 2;
      if (popNow) begin
         expW = expQ.pop_front();
         void'(takeQ.pop_front());
      end
      #1;
      if (popNow) begin
         cmpWord("copy A", expW, {gatedDataOut, csOut, odtOut, ckeOut});
         cmpWord("copy B", fanMode ? expW : 28'h0, {gatedDataOutB, csOutB, odtOutB, ckeOutB});
      end
      heldA = {gatedDataOut, csOut, odtOut, ckeOut};
   end

   // copy A outputs stay put while inputs change between edges
   always @(negedge clock) begin
      #2;
      if (rstn === 1'b1) begin
         cmpWord("hold A", heldA, {gatedDataOut, csOut, odtOut, ckeOut});
      end
   end

   // Walks every strap setting with prompt, stalled and refused traffic.
   initial begin
      {rstn, pinoutSelect, fanoutSelect, zHigh, zLow, csPrim, csSec, odtIn, ckeIn} = '0;
      dataInBit = '0;
      paceMode = 2'h0;
      fanMode = 1'b0;
      mask = '0;
      lastData = '0;
      for (int m = 0; m < 4; m++) begin
         doReset(1'(m[0]), 1'(m[1]));
         paceMode = 2'h0;
         repeat (30) sendWord();
         paceMode = 2'h1;
         repeat (60) sendWord();
         fillUp();
      end
      doReset(1'b0, 1'b0);
      paceMode = 2'h0;
      repeat (20) sendWord();
      stop_test();
   end

   // Cuts a hung run short far beyond the roughly 520 cycles it needs.
   initial begin
      #100000;
      miscompares++;
      stop_test();
   end
endmodule
`default_nettype wire
